/* verilog/uos_pkg.sv */
// Package with register map, field positions and timing for the OTG status block.
package uos_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SOF = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_BDT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;
  localparam int BIT_CABLE = 7;
  localparam int BIT_LINE_STABLE = 5;
  localparam int BIT_SESS_VALID = 3;
  localparam int BIT_B_SESS_END = 2;
  localparam int BIT_A_VBUS_VALID = 0;
  localparam logic [7:0] STATUS_IMPL_MASK = 8'had;
  localparam int SOF_W = 8;
  localparam int BDT_LSB = 1;
  localparam int BDT_W = 7;
  localparam int BDT_ALIGN_BITS = 9;
  localparam logic [SOF_W-1:0] SOF_RESET = 8'h00;
  localparam logic [BDT_W-1:0] BDT_RESET = 7'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int CLK_PERIOD_PS = 5000;
  localparam longint LINE_STABLE_PS = 64'd1000000000;
  localparam int LINE_STABLE_CYCLES =
    int'((LINE_STABLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
endpackage : uos_pkg

/* verilog/uos_line_stable.sv */
// Line state stability timer for the single-ended-zero and J-state indications.
module uos_line_stable
  import uos_pkg::*;
#(
  parameter int STABLE_CYCLES = LINE_STABLE_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic se0_i,
  input wire logic j_state_flag_i,
  output logic stable_o
);
  localparam int CNT_W = $clog2(STABLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYCLES - 1);

  logic se0_prev_q;
  logic j_prev_q;
  logic [CNT_W-1:0] cnt_q;
  logic changed;

  assign changed = (se0_i != se0_prev_q) || (j_state_flag_i != j_prev_q);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      se0_prev_q <= 1'b0;
      j_prev_q <= 1'b0;
    end else begin
      se0_prev_q <= se0_i;
      j_prev_q <= j_state_flag_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (changed) begin
      cnt_q <= '0;
    end else if (cnt_q < CNT_LAST) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stable_o <= 1'b0;
    end else begin
      stable_o <= !changed && (cnt_q >= CNT_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_stable_needs_count;
    @(posedge clk_sys_i) disable iff (rst_i)
    stable_o |-> $past(cnt_q) >= CNT_LAST;
  endproperty
  a_stable_needs_count: assert property (p_stable_needs_count)
    else $error("Line stable set before the full interval.");

  property p_restart;
    @(posedge clk_sys_i) disable iff (rst_i)
    changed |=> cnt_q == '0 && !stable_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("Stability timer did not restart on a change.");
endmodule : uos_line_stable

/* verilog/uos_otg_status.sv */
// OTG cable and session status, frame start threshold and descriptor table base registers.
// Operation
// - The cable type bit reads 1 with no cable or a type B cable and 0 with a type A cable.
// - The line stable bit reads 1 only when SE0 and J-state were unchanged for the last 1 ms.
// - The session valid bit follows VBUS being above the session valid threshold.
// - The B-side session end bit reads 1 while VBUS is below the session valid threshold.
// - The A-side VBUS valid bit reads 1 while VBUS is above the session valid threshold.
// - An 8-bit read/write frame start threshold count is provided, cleared at reset.
// - A 7-bit read/write field gives table base address bits 15 to 9, lower nine bits zero.
// - Bits 31 to 8 and unimplemented bits read zero and ignore writes.
//
// Strobed register access and the register addresses were decided locally.
module uos_otg_status
  import uos_pkg::*;
#(
  parameter int STABLE_CYCLES = LINE_STABLE_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic cable_type_indicator_i,
  input wire logic se0_i,
  input wire logic j_state_flag_i,
  input wire logic vbus_above_sess_i,
  output logic [SOF_W-1:0] sof_threshold_count_o,
  output logic [15:0] descriptor_table_base_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_mask_q;
  logic [SOF_W-1:0] sof_q;
  logic [BDT_W-1:0] bdt_q;
  logic line_stable;
  logic [7:0] events;
  logic [DATA_W-1:0] rdata_d;
  logic status_live_q;

  uos_line_stable #(
    .STABLE_CYCLES(STABLE_CYCLES)
  ) u_line_stable (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .se0_i(se0_i),
    .j_state_flag_i(j_state_flag_i),
    .stable_o(line_stable)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    status_d = STATUS_RESET;
    status_d[BIT_CABLE] = cable_type_indicator_i;
    status_d[BIT_LINE_STABLE] = line_stable;
    status_d[BIT_SESS_VALID] = vbus_above_sess_i;
    status_d[BIT_B_SESS_END] = !vbus_above_sess_i;
    status_d[BIT_A_VBUS_VALID] = vbus_above_sess_i;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sof_q <= SOF_RESET;
    end else if (wr_i && hit(addr_i, OFF_SOF)) begin
      sof_q <= wdata_i[SOF_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      bdt_q <= BDT_RESET;
    end else if (wr_i && hit(addr_i, OFF_BDT)) begin
      bdt_q <= wdata_i[BDT_LSB +: BDT_W];
    end
  end

  assign sof_threshold_count_o = sof_q;
  assign descriptor_table_base_o = {bdt_q, {BDT_ALIGN_BITS{1'b0}}};

  ////////////////////////////////////////////////////////////////////////////
  // Events wait one cycle after reset.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      status_live_q <= 1'b0;
    end else begin
      status_live_q <= 1'b1;
    end
  end

  assign events = status_live_q ? ((status_q ^ status_d) & STATUS_IMPL_MASK) : 8'h00;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_q <= 8'h00;
    end else if (wr_i && hit(addr_i, OFF_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~wdata_i[7:0]) | events;
    end else begin
      irq_stat_q <= irq_stat_q | events;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask_q <= 8'h00;
    end else if (wr_i && hit(addr_i, OFF_IRQ_MASK)) begin
      irq_mask_q <= wdata_i[7:0] & STATUS_IMPL_MASK;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata_d = '0;
    if (hit(addr_i, OFF_STATUS)) begin
      rdata_d[7:0] = status_q & STATUS_IMPL_MASK;
    end else if (hit(addr_i, OFF_SOF)) begin
      rdata_d[SOF_W-1:0] = sof_q;
    end else if (hit(addr_i, OFF_BDT)) begin
      rdata_d[BDT_LSB +: BDT_W] = bdt_q;
    end else if (hit(addr_i, OFF_IRQ_STAT)) begin
      rdata_d[7:0] = irq_stat_q;
    end else if (hit(addr_i, OFF_IRQ_MASK)) begin
      rdata_d[7:0] = irq_mask_q;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rdata_d;
    end else begin
      rdata_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_cable;
    @(posedge clk_sys_i) disable iff (rst_i)
    !rst_i |=> status_q[BIT_CABLE] == $past(cable_type_indicator_i);
  endproperty
  a_cable: assert property (p_cable)
    else $error("Cable type bit does not follow the cable type level.");

  property p_line_change;
    @(posedge clk_sys_i) disable iff (rst_i)
    ($changed(se0_i) || $changed(j_state_flag_i)) |-> ##2 !status_q[BIT_LINE_STABLE];
  endproperty
  a_line_change: assert property (p_line_change)
    else $error("Line stable bit high right after a line change.");

  property p_sess;
    @(posedge clk_sys_i) disable iff (rst_i)
    !rst_i |=> status_q[BIT_SESS_VALID] == $past(vbus_above_sess_i);
  endproperty
  a_sess: assert property (p_sess)
    else $error("Session valid bit does not follow VBUS.");

  property p_sess_end;
    @(posedge clk_sys_i) disable iff (rst_i)
    !rst_i |=> status_q[BIT_B_SESS_END] == !$past(vbus_above_sess_i);
  endproperty
  a_sess_end: assert property (p_sess_end)
    else $error("Session end bit wrong.");

  property p_vbus_valid;
    @(posedge clk_sys_i) disable iff (rst_i)
    status_q[BIT_A_VBUS_VALID] == status_q[BIT_SESS_VALID];
  endproperty
  a_vbus_valid: assert property (p_vbus_valid)
    else $error("VBUS valid bit disagrees with session valid.");

  property p_sof_rw;
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == OFF_SOF) ##1 (rd_i && addr_i == OFF_SOF)
      |=> rdata_o == {24'h000000, $past(wdata_i[7:0], 2)};
  endproperty
  a_sof_rw: assert property (p_sof_rw)
    else $error("Threshold count readback mismatch.");

  property p_bdt;
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == OFF_BDT) |=> descriptor_table_base_o ==
      {$past(wdata_i[7:1]), 9'h000};
  endproperty
  a_bdt: assert property (p_bdt)
    else $error("Table base does not hold the written bits.");

  property p_upper_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
    rd_i |=> rdata_o[31:8] == 24'h000000 && rdata_o[6] == 1'b0 ||
      $past(addr_i) != OFF_STATUS && rdata_o[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("Unimplemented bits read nonzero.");

  property p_status_ro;
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == OFF_STATUS) |=> status_q[BIT_CABLE] == $past(cable_type_indicator_i);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("Status register took a write.");

  property p_irq;
    @(posedge clk_sys_i) disable iff (rst_i)
    1'b1 |=> irq_o == $past(|(irq_stat_q & irq_mask_q));
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt output disagrees with status and mask.");

  property p_irq_w1c;
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == OFF_IRQ_STAT) |=>
      (irq_stat_q & $past(wdata_i[7:0]) & ~$past(events)) == 8'h00;
  endproperty
  a_irq_w1c: assert property (p_irq_w1c)
    else $error("Interrupt status bit survived a write of one.");

  property p_irq_set;
    @(posedge clk_sys_i) disable iff (rst_i)
    (|events) |=> (irq_stat_q & $past(events)) == $past(events);
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("Status change did not set its interrupt bit.");

  property p_irq_impl;
    @(posedge clk_sys_i) disable iff (rst_i)
    ((irq_stat_q | irq_mask_q) & ~STATUS_IMPL_MASK) == 8'h00;
  endproperty
  a_irq_impl: assert property (p_irq_impl)
    else $error("Unimplemented interrupt bit set.");

  property p_live;
    @(posedge clk_sys_i) disable iff (rst_i)
    (!rst_i && !status_live_q) |=> irq_stat_q == 8'h00;
  endproperty
  a_live: assert property (p_live)
    else $error("Interrupt event raised by the reset values.");

  property p_sof_out;
    @(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == OFF_SOF) |=> sof_threshold_count_o == $past(wdata_i[SOF_W-1:0]);
  endproperty
  a_sof_out: assert property (p_sof_out)
    else $error("Threshold count output does not hold the written value.");

  property p_status_read;
    @(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == OFF_STATUS) |=> (rdata_o[7:0] & ~STATUS_IMPL_MASK) == 8'h00;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Unimplemented status bit reads nonzero.");

  property p_bdt_read;
    @(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == OFF_BDT) |=> rdata_o[7:0] == {descriptor_table_base_o[15:9], 1'b0};
  endproperty
  a_bdt_read: assert property (p_bdt_read)
    else $error("Table base field reads back wrong.");

  property p_rdata_idle;
    @(posedge clk_sys_i) disable iff (rst_i)
    !rd_i |=> rdata_o == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data stood beyond its cycle.");

  c_type_a: cover property (@(posedge clk_sys_i) disable iff (rst_i) !status_q[BIT_CABLE]);
  c_stable: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(status_q[BIT_LINE_STABLE]));
  c_irq: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(irq_o));
  c_sof_back_to_back: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == OFF_SOF) ##1 (rd_i && addr_i == OFF_SOF));
  c_w1c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_i && addr_i == OFF_IRQ_STAT && |irq_stat_q);
endmodule : uos_otg_status

/* tb/uos_cable_model.sv */
// Behavioural model of the cable, VBUS comparator and line-state monitor.
module uos_cable_model
  import uos_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic cable_req_i,
  input wire logic vbus_req_i,
  input wire logic se0_req_i,
  input wire logic j_req_i,
  output logic cable_type_indicator_o,
  output logic se0_o,
  output logic j_state_flag_o,
  output logic vbus_above_sess_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Levels settle one clock after the far side changes them.
  always_ff @(posedge clk_sys_i) begin
    cable_type_indicator_o <= cable_req_i;
    vbus_above_sess_o <= vbus_req_i;
    se0_o <= se0_req_i;
    j_state_flag_o <= j_req_i;
  end
endmodule : uos_cable_model

/* tb/uos_otg_status_test.sv */
// Self-checking bench for the OTG status, frame threshold and table base registers.
module uos_otg_status_test
  import uos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STB = 16;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic cable_q = 1'b1;
  logic vbus_q = 1'b0;
  logic se0_q = 1'b0;
  logic jst_q = 1'b1;
  logic cable_w, se0_w, jst_w, vbus_w, irq_w;
  logic [SOF_W-1:0] sof_w;
  logic [15:0] base_w;
  logic [DATA_W-1:0] d;
  logic [7:0] typ [4] = '{8'h4a, 8'h2a, 8'h1a, 8'h12};
  int fails = 0;
  int samples_checked = 0;

  uos_cable_model u_uos_cable_model (.clk_sys_i(clk_sys_i), .cable_req_i(cable_q),
    .vbus_req_i(vbus_q), .se0_req_i(se0_q), .j_req_i(jst_q),
    .cable_type_indicator_o(cable_w), .se0_o(se0_w), .j_state_flag_o(jst_w),
    .vbus_above_sess_o(vbus_w));
  uos_otg_status #(.STABLE_CYCLES(STB)) u_uos_otg_status (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .cable_type_indicator_i(cable_w), .se0_i(se0_w),
    .j_state_flag_i(jst_w), .vbus_above_sess_i(vbus_w), .sof_threshold_count_o(sof_w),
    .descriptor_table_base_o(base_w), .irq_o(irq_w));

  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [DATA_W-1:0] exp_status(input logic c, input logic v, input logic s);
    return {24'h000000, c, 1'b0, s, 1'b0, v, ~v, 1'b0, v};
  endfunction : exp_status
  task automatic stop_test();
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : bus_wr
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : rd_chk
  task automatic wr_rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
    input logic [DATA_W-1:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : wr_rd_chk
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    stop_test();
  end
  initial begin
    d = $urandom(34072);
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd_chk(OFF_SOF, 32'h00000000);
    rd_chk(OFF_BDT, 32'h00000000);
    repeat (STB + 8) @(posedge clk_sys_i);
    rd_chk(OFF_STATUS, exp_status(1'b1, 1'b0, 1'b1));
    @(posedge clk_sys_i) se0_q <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rd_chk(OFF_STATUS, exp_status(1'b1, 1'b0, 1'b0));
    repeat (STB - 8) @(posedge clk_sys_i);
    jst_q <= 1'b0;
    repeat (STB - 8) @(posedge clk_sys_i);
    rd_chk(OFF_STATUS, exp_status(1'b1, 1'b0, 1'b0));
    repeat (STB + 8) @(posedge clk_sys_i);
    rd_chk(OFF_STATUS, exp_status(1'b1, 1'b0, 1'b1));
    for (int i = 0; i < 12; i++) begin
      cable_q <= 1'($urandom);
      vbus_q <= 1'($urandom);
      repeat (4) @(posedge clk_sys_i);
      rd_chk(OFF_STATUS, exp_status(cable_q, vbus_q, 1'b1));
      chk({31'h0, irq_w}, 32'h00000000);
    end
    bus_wr(OFF_STATUS, 32'hffffffff);
    rd_chk(OFF_STATUS, exp_status(cable_q, vbus_q, 1'b1));
    for (int i = 0; i < 4; i++) begin
      wr_rd_chk(OFF_SOF, {24'hffffff, typ[i]}, {24'h000000, typ[i]});
      chk({24'h000000, sof_w}, {24'h000000, typ[i]});
    end
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      bus_wr(OFF_SOF, d);
      bus_wr(OFF_BDT, d);
      rd_chk(OFF_SOF, {24'h000000, d[7:0]});
      rd_chk(OFF_BDT, {24'h000000, d[7:1], 1'b0});
      chk({16'h0000, base_w}, {16'h0000, d[7:1], 9'h000});
    end
    bus_wr(8'h14, $urandom);
    rd_chk(8'h14, 32'h00000000);
    bus_wr(OFF_IRQ_MASK, 32'hffffffff);
    rd_chk(OFF_IRQ_MASK, 32'h000000ad);
    bus_wr(OFF_IRQ_MASK, 32'h00000008);
    bus_wr(OFF_IRQ_STAT, 32'h000000ff);
    rd_chk(OFF_IRQ_STAT, 32'h00000000);
    @(posedge clk_sys_i) vbus_q <= ~vbus_q;
    repeat (6) @(posedge clk_sys_i);
    chk({31'h0, irq_w}, 32'h00000001);
    rd_chk(OFF_IRQ_STAT, 32'h0000000d);
    bus_wr(OFF_IRQ_STAT, 32'h00000008);
    repeat (3) @(posedge clk_sys_i);
    chk({31'h0, irq_w}, 32'h00000000);
    rd_chk(OFF_IRQ_STAT, 32'h00000005);
    @(posedge clk_sys_i) rst_i <= 1'b1;
    @(posedge clk_sys_i) rst_i <= 1'b0;
    rd_chk(OFF_SOF, 32'h00000000);
    chk({16'h0000, base_w}, 32'h00000000);
    stop_test();
  end
endmodule : uos_otg_status_test
